// ===== include/cdv_pkg.sv
package cdv_pkg;

	// ----------------------------------------
	// Register map (plain port, word index)
	// ----------------------------------------
	localparam int          CDV_ADDR_W          = 2;
	localparam int          CDV_DATA_W          = 16;
	localparam logic [1:0]  CDV_ADDR_CTRL       = 2'h0;
	localparam logic [1:0]  CDV_ADDR_WINDOW     = 2'h1;

	// ----------------------------------------
	// Value pointer codes
	// ----------------------------------------
	localparam logic [1:0]  CDV_PTR_YEAR        = 2'h3;
	localparam logic [1:0]  CDV_PTR_MONTH_DAY   = 2'h2;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int          CDV_CTRL_UNLOCK_BIT = 0;
	localparam int          CDV_CTRL_PTR_LSB    = 8;
	localparam logic [1:0]  CDV_PTR_RESET       = 2'h0;
	localparam logic        CDV_UNLOCK_RESET    = 1'b0;

	// ----------------------------------------
	// Digit field positions
	// ----------------------------------------
	localparam int          CDV_YEAR_TENS_LSB   = 4;
	localparam int          CDV_YEAR_ONES_LSB   = 0;
	localparam int          CDV_MONTH_TENS_BIT  = 12;
	localparam int          CDV_MONTH_ONES_LSB  = 8;
	localparam int          CDV_DAY_TENS_LSB    = 4;
	localparam int          CDV_DAY_ONES_LSB    = 0;

	// Writable masks of the two date registers
	localparam logic [15:0] CDV_YEAR_MASK       = 16'h00ff;
	localparam logic [15:0] CDV_MONTH_DAY_MASK  = 16'h1f3f;

	typedef enum logic [1:0] {
		CDV_SEL_OTHER,
		CDV_SEL_YEAR,
		CDV_SEL_MONTH_DAY
	} cdv_sel_t;

endpackage

// ===== hdl/cdv_date_regs.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Operation
// - Pointer 11 maps year onto window
// - Pointer 10 maps month-day onto window
// - Year tens bits 7-4, ones 3-0
// - Month tens single bit 12
// - Month ones bits 11-8
// - Day tens bits 5-4
// - Day ones bits 3-0
// - Date writes accepted only while unlocked
// - Unimplemented bits read as zero
// - Digits read/write, undefined after power-on
module cdv_date_regs
	import cdv_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	input  wire logic [CDV_ADDR_W-1:0] reg_addr,
	input  wire logic [CDV_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [CDV_DATA_W-1:0] reg_rdata,
	output logic      [1:0]            value_pointer,
	output logic                       value_write_unlock,
	output logic      [3:0]            year_tens,
	output logic      [3:0]            year_ones,
	output logic                       month_tens,
	output logic      [3:0]            month_ones,
	output logic      [1:0]            day_tens,
	output logic      [3:0]            day_ones
);

	// ----------------------------------------
	// Local field widths
	// ----------------------------------------
	localparam int PTR_W        = 2;
	localparam int DIGIT_W      = 4;
	localparam int MONTH_TENS_W = 1;
	localparam int DAY_TENS_W   = 2;
	localparam int N_DIGITS     = 6;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [PTR_W-1:0]      ptr;
		logic                  unlock;
		logic [15:0]           year;
		logic [15:0]           md;
		logic [CDV_DATA_W-1:0] rdata;
	} cdv_state_t;

	cdv_state_t s_q;
	cdv_state_t s_d;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Ones over a field of the given position and width
	function automatic logic [15:0] cdv_field_mask(
		input int lsb,
		input int width
	);
		logic [15:0] m;
		m = '0;
		for (int i = 0; i < 16; i++) begin
			if (i >= lsb && i < lsb + width) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	// Which date register the pointer selects
	function automatic cdv_sel_t cdv_decode(
		input logic [PTR_W-1:0] p
	);
		case (p)
			CDV_PTR_YEAR: begin
				cdv_decode = CDV_SEL_YEAR;
			end
			CDV_PTR_MONTH_DAY: begin
				cdv_decode = CDV_SEL_MONTH_DAY;
			end
			default: begin
				cdv_decode = CDV_SEL_OTHER;
			end
		endcase
	endfunction

	// Implemented bits of the selected date register
	function automatic logic [15:0] cdv_window_mask(
		input cdv_sel_t sel
	);
		case (sel)
			CDV_SEL_YEAR: begin
				cdv_window_mask = CDV_YEAR_MASK;
			end
			CDV_SEL_MONTH_DAY: begin
				cdv_window_mask = CDV_MONTH_DAY_MASK;
			end
			default: begin
				cdv_window_mask = '0;
			end
		endcase
	endfunction

	// Read image of the control register
	function automatic logic [CDV_DATA_W-1:0] cdv_ctrl_image(
		input logic [PTR_W-1:0] ptr,
		input logic             unlock
	);
		logic [CDV_DATA_W-1:0] img;
		img = '0;
		img[CDV_CTRL_UNLOCK_BIT]        = unlock;
		img[CDV_CTRL_PTR_LSB +: PTR_W]  = ptr;
		return img;
	endfunction

	// Bit position of each digit, year first, tens before ones
	function automatic int cdv_digit_lsb(input int idx);
		case (idx)
			0:       return CDV_YEAR_TENS_LSB;
			1:       return CDV_YEAR_ONES_LSB;
			2:       return CDV_MONTH_TENS_BIT;
			3:       return CDV_MONTH_ONES_LSB;
			4:       return CDV_DAY_TENS_LSB;
			5:       return CDV_DAY_ONES_LSB;
			default: return 0;
		endcase
	endfunction

	// Width of each digit, same order
	function automatic int cdv_digit_width(input int idx);
		case (idx)
			0:       return DIGIT_W;
			1:       return DIGIT_W;
			2:       return MONTH_TENS_W;
			3:       return DIGIT_W;
			4:       return DAY_TENS_W;
			5:       return DIGIT_W;
			default: return 0;
		endcase
	endfunction

	// The first two digits live in the year register
	function automatic bit cdv_digit_in_year(input int idx);
		return idx < 2;
	endfunction

	// ----------------------------------------
	// Field masks built from the digit positions
	// ----------------------------------------
	localparam logic [15:0] YEAR_FIELDS =
		cdv_field_mask(CDV_YEAR_TENS_LSB, DIGIT_W) |
		cdv_field_mask(CDV_YEAR_ONES_LSB, DIGIT_W);
	localparam logic [15:0] MONTH_DAY_FIELDS =
		cdv_field_mask(CDV_MONTH_TENS_BIT, MONTH_TENS_W) |
		cdv_field_mask(CDV_MONTH_ONES_LSB, DIGIT_W) |
		cdv_field_mask(CDV_DAY_TENS_LSB, DAY_TENS_W) |
		cdv_field_mask(CDV_DAY_ONES_LSB, DIGIT_W);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	generate
		if (CDV_DATA_W != 16) begin : g_bad_width
			$error("cdv_date_regs: register width must be 16");
		end
		if (CDV_ADDR_W < 1) begin : g_bad_addr
			$error("cdv_date_regs: address needs at least one bit");
		end
		if (CDV_CTRL_PTR_LSB + PTR_W > CDV_DATA_W) begin : g_bad_ptr
			$error("cdv_date_regs: pointer field outside the control register");
		end
		if (CDV_CTRL_UNLOCK_BIT >= CDV_DATA_W) begin : g_bad_unlock
			$error("cdv_date_regs: unlock bit outside the control register");
		end
		if (CDV_CTRL_UNLOCK_BIT >= CDV_CTRL_PTR_LSB &&
		    CDV_CTRL_UNLOCK_BIT < CDV_CTRL_PTR_LSB + PTR_W) begin : g_bad_overlap
			$error("cdv_date_regs: unlock bit overlaps the pointer field");
		end
		if (YEAR_FIELDS != CDV_YEAR_MASK) begin : g_bad_year_mask
			$error("cdv_date_regs: year mask does not match its digits");
		end
		if (MONTH_DAY_FIELDS != CDV_MONTH_DAY_MASK) begin : g_bad_md_mask
			$error("cdv_date_regs: month-day mask does not match its digits");
		end
		if (CDV_PTR_YEAR == CDV_PTR_MONTH_DAY) begin : g_bad_codes
			$error("cdv_date_regs: pointer codes must differ");
		end
		if (CDV_ADDR_CTRL == CDV_ADDR_WINDOW) begin : g_bad_map
			$error("cdv_date_regs: control and window indexes must differ");
		end
	endgenerate

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// Unmapped indexes read zero and ignore writes
	logic        ctrl_wr;
	logic        ctrl_rd;
	logic        win_wr;
	logic        win_rd;
	cdv_sel_t    sel;
	logic [15:0] win_mask;

	assign ctrl_wr  = reg_wr && (reg_addr == CDV_ADDR_CTRL);
	assign ctrl_rd  = reg_rd && (reg_addr == CDV_ADDR_CTRL);
	assign win_wr   = reg_wr && (reg_addr == CDV_ADDR_WINDOW);
	assign win_rd   = reg_rd && (reg_addr == CDV_ADDR_WINDOW);
	assign sel      = cdv_decode(s_q.ptr);
	assign win_mask = cdv_window_mask(sel);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d       = s_q;
		s_d.rdata = '0;
		// Pointer and unlock bit
		if (ctrl_wr) begin
			s_d.unlock = reg_wdata[CDV_CTRL_UNLOCK_BIT];
			s_d.ptr    = reg_wdata[CDV_CTRL_PTR_LSB +: PTR_W];
		end
		// Window writes use the pointer from before this edge
		if (win_wr && s_q.unlock) begin
			case (sel)
				CDV_SEL_YEAR: begin
					s_d.year = reg_wdata & win_mask;
				end
				CDV_SEL_MONTH_DAY: begin
					s_d.md = reg_wdata & win_mask;
				end
				default: begin
					// Time and weekday registers live outside this block
					s_d.md = s_q.md;
				end
			endcase
		end
		// Read data stands for one cycle, zero otherwise
		if (ctrl_rd) begin
			s_d.rdata = cdv_ctrl_image(s_q.ptr, s_q.unlock);
		end
		if (win_rd) begin
			case (sel)
				CDV_SEL_YEAR: begin
					s_d.rdata = s_q.year & win_mask;
				end
				CDV_SEL_MONTH_DAY: begin
					s_d.rdata = s_q.md & win_mask;
				end
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Registers; date digits keep no reset value
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		s_q <= s_d;
		if (!resetn) begin
			s_q.ptr    <= CDV_PTR_RESET;
			s_q.unlock <= CDV_UNLOCK_RESET;
			s_q.rdata  <= '0;
		end
	end

	// ----------------------------------------
	// Digit view of the two date registers
	// ----------------------------------------
	// Each digit is right-aligned in its slot
	logic [DIGIT_W-1:0] digit_view [N_DIGITS];

	for (genvar g = 0; g < N_DIGITS; g++) begin : g_digit
		localparam int LSB     = cdv_digit_lsb(g);
		localparam int WID     = cdv_digit_width(g);
		localparam bit IN_YEAR = cdv_digit_in_year(g);
		logic [15:0] src;

		if (LSB + WID > 16) begin : g_bad_field
			$error("cdv_date_regs: digit field outside the register");
		end
		if (WID > DIGIT_W) begin : g_bad_slot
			$error("cdv_date_regs: digit wider than its slot");
		end
		assign src           = IN_YEAR ? s_q.year : s_q.md;
		assign digit_view[g] = DIGIT_W'((src >> LSB) & ((16'h1 << WID) - 16'h1));
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata          = s_q.rdata;
	assign value_pointer      = s_q.ptr;
	assign value_write_unlock = s_q.unlock;
	assign year_tens          = digit_view[0];
	assign year_ones          = digit_view[1];
	assign month_tens         = digit_view[2][0];
	assign month_ones         = digit_view[3];
	assign day_tens           = digit_view[4][1:0];
	assign day_ones           = digit_view[5];

endmodule

// ===== verification/cdv_date_regs_checker.sv
`timescale 1ns/1ps
module cdv_date_regs_checker
	import cdv_pkg::*;
(
	input wire logic        ref_clk, resetn, reg_wr, reg_rd, value_write_unlock, month_tens,
	input wire logic [1:0]  reg_addr, value_pointer, day_tens,
	input wire logic [15:0] reg_wdata, reg_rdata,
	input wire logic [3:0]  year_tens, year_ones, month_ones, day_ones
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire logic [18:0] dig = {year_tens, year_ones, month_tens, month_ones, day_tens, day_ones};
	wire logic        ww  = reg_wr && reg_addr == CDV_ADDR_WINDOW;
	wire logic        wr  = reg_rd && reg_addr == CDV_ADDR_WINDOW;
	sequence s_yw; ww && value_write_unlock && value_pointer == CDV_PTR_YEAR; endsequence
	sequence s_mw; ww && value_write_unlock && value_pointer == CDV_PTR_MONTH_DAY; endsequence
	AST_YR_WR: assert property (s_yw |=> dig[18:11] == $past(reg_wdata[7:0])) else $error("year");
	AST_MTH_WR: assert property (s_mw |=> dig[10:6] == $past(reg_wdata[12:8])) else $error("month");
	AST_DAY_WR: assert property (s_mw |=> dig[5:0] == $past(reg_wdata[5:0])) else $error("day");
	AST_LOCKED: assert property (ww && !value_write_unlock |=> $stable(dig)) else $error("locked");
	AST_YR_RD: assert property (wr && value_pointer == CDV_PTR_YEAR |=> reg_rdata == {8'h00, dig[18:11]})
		else $error("year read");
	AST_MD_RD: assert property (wr && value_pointer == CDV_PTR_MONTH_DAY |=>
		reg_rdata == {3'h0, dig[10:6], 2'h0, dig[5:0]}) else $error("month read");
	AST_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0) else $error("idle");
	AST_UNMAP: assert property (reg_rd && reg_addr[1] |=> reg_rdata == 16'h0) else $error("unmapped");
endmodule
bind cdv_date_regs cdv_date_regs_checker u_chk (.*);

// ===== verification/tb_cdv_date_regs.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED %0t %h", $time, a); end end
module tb_cdv_date_regs;
	import cdv_pkg::*;
	logic        ref_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, value_write_unlock, month_tens;
	logic [1:0]  reg_addr = 2'h0, value_pointer, day_tens;
	logic [15:0] reg_wdata = 16'h0, reg_rdata, yr = 16'h0, md = 16'h0;
	logic [3:0]  year_tens, year_ones, month_ones, day_ones;
	logic [31:0] r;
	int          seed = 69417, n_fail = 0, cmp_count = 0;
	cdv_date_regs uut (.*);
	always #20 ref_clk = ~ref_clk;
	task acc(input logic w, input logic [1:0] a, input logic [15:0] v);
		@(posedge ref_clk) begin
			reg_wr <= w;
			reg_rd <= !w;
			reg_addr <= a;
			reg_wdata <= v;
		end
		@(posedge ref_clk) begin
			reg_wr <= 1'h0;
			reg_rd <= 1'h0;
		end
		#1 if (!w) `CHK(reg_rdata, v)
	endtask
	function logic [15:0] expv(input logic [1:0] q);
		return q == CDV_PTR_YEAR ? yr : q == CDV_PTR_MONTH_DAY ? md : 16'h0;
	endfunction
	task step(input logic u, input logic [1:0] q, input logic [15:0] v);
		acc(1'h1, CDV_ADDR_CTRL, {6'h0, q, 7'h0, u});
		`CHK({value_pointer, value_write_unlock}, {q, u})
		acc(1'h0, CDV_ADDR_CTRL, {6'h0, q, 7'h0, u});
		acc(1'h1, CDV_ADDR_WINDOW, v);
		if (u && q == CDV_PTR_YEAR) yr = v & CDV_YEAR_MASK;
		if (u && q == CDV_PTR_MONTH_DAY) md = v & CDV_MONTH_DAY_MASK;
		`CHK({month_tens, month_ones, day_tens, day_ones}, {md[12:8], md[5:0]})
		`CHK({year_tens, year_ones}, yr[7:0])
		acc(1'h0, CDV_ADDR_WINDOW, expv(q));
	endtask
	task conclude;
		$display("checks %0d failures %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		resetn <= 1'h1;
		acc(1'h1, CDV_ADDR_CTRL, 16'h0301);
		acc(1'h1, CDV_ADDR_WINDOW, 16'h0024);
		yr = 16'h0024;
		acc(1'h1, CDV_ADDR_CTRL, 16'h0201);
		acc(1'h1, CDV_ADDR_WINDOW, 16'h1231);
		md = 16'h1231;
		step(1'h1, CDV_PTR_YEAR, 16'hff99);
		step(1'h1, CDV_PTR_MONTH_DAY, 16'hffff);
		step(1'h0, CDV_PTR_YEAR, 16'h0000);
		acc(1'h1, 2'h3, 16'hffff);
		acc(1'h0, 2'h2, 16'h0000);
		for (int i = 0; i < 300; i++) begin
			r = $random(seed);
			step(r[20], r[17:16], r[15:0]);
		end
		conclude;
	end
endmodule
